// ### vcf_cmd_front.v
// vcf_cmd_front.v: command front end of a bit-serial slice decoder
// assumes an ahb-lite master writes command dwords to the command port in order
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "vcf_map.vh"
module vcf_cmd_front #(
  parameter AW = 8 // register address bits decoded
) (
  input wire CORE_CLK, // 40 MHz clock
  input wire RST_N, // synchronous reset, active low
  input wire HSEL, // slave select
  input wire [31:0] HADDR, // byte address
  input wire [1:0] HTRANS, // transfer type
  input wire HWRITE, // write when high
  input wire [2:0] HSIZE, // transfer size
  input wire [31:0] HWDATA, // write data
  input wire HREADY, // bus ready in
  output wire HREADYOUT, // always ready
  output wire HRESP, // always okay
  output reg [31:0] HRDATA, // read data
  input wire [31:0] IND_START, // slice indirect start address
  input wire IND_DATA_VALID, // fetched indirect data valid
  input wire [31:0] IND_DATA_IN, // fetched indirect data from memory
  input wire [31:0] IND_DATA_ADDR, // address the fetched data came from
  output reg [31:0] IND_ADDR_OUT, // base plus start address
  output reg IND_OUT_VALID, // filtered data valid
  output reg [31:0] IND_DATA_OUT, // data after range check
  output reg [7:0] PIC_HEIGHT_MB, // picture height in macroblocks
  output reg [7:0] PIC_WIDTH_MB, // picture width in macroblocks
  output reg CONCEAL_ENABLE, // fill missing macroblocks
  output reg [4:0] ALT_PIC_QUANT, // alternative picture quantizer
  output reg DEBLOCK_INFO_EN, // deblocking info to video front end
  output reg OVERLAP_EN, // picture overlap smoothing
  output reg IMPLICIT_QUANT_FLAG, // quantizer element was zero
  output reg [4:0] PIC_QUANT, // picture quantizer
  output reg [3:0] ALT_QUANT_EDGE_MASK, // edge mask, zero unless config 01
  output reg [1:0] ALT_QUANT_CONFIG, // alternative quantizer use
  output reg HALF_STEP_QUANT_FLAG, // half-step quantizer
  output reg UNIFORM_QUANT_FLAG, // uniform ac quantization
  output reg [1:0] COND_OVERLAP, // conditional overlap mode
  output reg PIC_STATE_PULSE // one cycle when picture state lands
);
  // parser states
  localparam ST_HDR = 2'h0;
  localparam ST_IND = 2'h1;
  localparam ST_PIC = 2'h2;
  localparam ST_SKIP = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] left_r;
  reg [2:0] idx_r;
  reg [19:0] base_r;
  reg [19:0] bound_r;
  reg [31:0] pic1_r;
  reg [31:0] pic2_r;
  reg [31:0] pic2_stage_r;
  reg [31:0] pic1_stage_r;
  reg [7:0] err_cnt_r;
  reg [7:0] ind_cnt_r;
  reg [7:0] pic_cnt_r;
  reg wr_pend_r;
  reg [AW-1:0] wr_addr_r;
  reg [AW-1:0] rd_addr_r;
  reg rd_pend_r;
  reg [15:0] zero_cnt_r;
  reg [15:0] pass_cnt_r;

  // header decode is used in two places, so it lives in a function
  function [1:0] hdr_kind;
    input [31:0] h;
    begin
      // a header that names this engine but no known command returns 0
      hdr_kind = 2'h0;
      if (h[31:29] == `VCF_CMD_TYPE && h[28:27] == `VCF_PIPE_BSD && h[26:24] == `VCF_OPC_VC1) begin
        if (h[23:16] == `VCF_SUB_IND && h[15:0] == `VCF_LEN_IND)
          hdr_kind = 2'h1;
        else if (h[23:16] == `VCF_SUB_PIC && h[15:0] == `VCF_LEN_PIC)
          hdr_kind = 2'h2;
      end
    end
  endfunction

  // out-of-range test on a 4 KB page number
  function out_of_range;
    input [19:0] page;
    input [19:0] bnd;
    begin
      out_of_range = (bnd != 20'h00000) && (page >= bnd);
    end
  endfunction

  // no wait states and no error responses, ever
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // write data of a command dword, valid in the data phase
  wire cmd_wr = wr_pend_r && (wr_addr_r == `VCF_REG_CMD);
  wire [1:0] kind = hdr_kind(HWDATA);
  wire [1:0] hdr_now = kind;

  // address phase capture; single-cycle answer, no wait states
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= {AW{1'b0}};
      rd_addr_r <= {AW{1'b0}};
    // only a ready cycle ends an address phase
    end else if (HREADY) begin
      wr_pend_r <= HSEL && HTRANS[1] && HWRITE;
      rd_pend_r <= HSEL && HTRANS[1] && !HWRITE;
      wr_addr_r <= HADDR[AW-1:0];
      rd_addr_r <= HADDR[AW-1:0];
    end
  end

  // command parser state, next value
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // a header decides which body follows; anything foreign stays here
      ST_HDR: begin
        if (cmd_wr) begin
          if (hdr_now == 2'h1)
            state_nxt = ST_IND;
          else if (hdr_now == 2'h2)
            state_nxt = ST_PIC;
          else if (HWDATA[31:29] == `VCF_CMD_TYPE)
            state_nxt = ST_SKIP; // unknown decoder command: drop its body
        end
      end
      // every body ends on the dword that finds no length left
      ST_IND, ST_PIC, ST_SKIP: begin
        if (cmd_wr && left_r == 16'h0000)
          state_nxt = ST_HDR;
      end
      // all four codes name states, so this is never taken; it falls back to header hunting
      default: state_nxt = ST_HDR;
    endcase
  end

  // parser and latches; dword 1 counts as the first body dword
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      // everything starts clean; an idle bound of zero leaves the check off
      state_r <= ST_HDR;
      left_r <= 16'h0000;
      idx_r <= 3'h0;
      base_r <= 20'h00000;
      bound_r <= 20'h00000;
      pic1_r <= 32'h00000000;
      pic2_r <= 32'h00000000;
      pic1_stage_r <= 32'h00000000;
      pic2_stage_r <= 32'h00000000;
      err_cnt_r <= 8'h00;
      ind_cnt_r <= 8'h00;
      pic_cnt_r <= 8'h00;
      PIC_STATE_PULSE <= 1'b0;
    end else begin
      state_r <= state_nxt;
      PIC_STATE_PULSE <= 1'b0;
      // only a command-port data phase moves the parser
      if (cmd_wr) begin
        case (state_r)
          // the length field counts body dwords beyond the first
          ST_HDR: begin
            idx_r <= 3'h1;
            left_r <= HWDATA[15:0]; // body length minus one
            if (hdr_now == 2'h0 && err_cnt_r != 8'hff)
              err_cnt_r <= err_cnt_r + 8'h01;
          end
          // indirect body: base page, then bound page
          ST_IND: begin
            idx_r <= idx_r + 3'h1;
            left_r <= left_r - 16'h0001;
            if (idx_r == 3'h1)
              base_r <= HWDATA[31:12]; // low 12 bits ignored
            if (idx_r == 3'h2) begin
              bound_r <= HWDATA[31:12];
              ind_cnt_r <= ind_cnt_r + 8'h01;
            end
          end
          // picture body: only dwords 1 and 2 carry fields this block uses
          ST_PIC: begin
            idx_r <= idx_r + 3'h1;
            left_r <= left_r - 16'h0001;
            if (idx_r == 3'h1)
              pic1_stage_r <= HWDATA;
            if (idx_r == 3'h2)
              pic2_stage_r <= HWDATA;
            // commit only once the whole command is in, so a slice never sees half a state
            if (left_r == 16'h0000) begin
              pic1_r <= pic1_stage_r;
              pic2_r <= pic2_stage_r;
              pic_cnt_r <= pic_cnt_r + 8'h01;
              PIC_STATE_PULSE <= 1'b1;
            end
          end
          // unknown decoder command: count its body away
          ST_SKIP: begin
            left_r <= left_r - 16'h0001;
          end
          default: idx_r <= 3'h0;
        endcase
      end
    end
  end

  // field slices of the held picture dwords; reserved bits are simply not picked
  wire [7:0] fld_height = pic1_r[23:16];
  wire [7:0] fld_width = pic1_r[7:0];
  wire fld_conceal = pic2_r[29];
  wire [4:0] fld_alt_quant = pic2_r[28:24];
  wire fld_loop_filter = pic2_r[23];
  wire fld_overlap = pic2_r[22];
  wire fld_implicit = pic2_r[21];
  wire [4:0] fld_quant = pic2_r[20:16];
  wire [3:0] fld_edge_mask = pic2_r[15:12];
  wire [1:0] fld_config = pic2_r[11:10];
  wire fld_half_step = pic2_r[9];
  wire fld_uniform = pic2_r[8];
  wire [1:0] fld_cond = pic2_r[7:6];

  // picture parameter outputs decoded from held dwords; reserved bits dropped
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      // outputs sit at zero until the first picture state lands
      PIC_HEIGHT_MB <= 8'h00;
      PIC_WIDTH_MB <= 8'h00;
      CONCEAL_ENABLE <= 1'b0;
      ALT_PIC_QUANT <= 5'h00;
      DEBLOCK_INFO_EN <= 1'b0;
      OVERLAP_EN <= 1'b0;
      IMPLICIT_QUANT_FLAG <= 1'b0;
      PIC_QUANT <= 5'h00;
      ALT_QUANT_EDGE_MASK <= 4'h0;
      ALT_QUANT_CONFIG <= 2'h0;
      HALF_STEP_QUANT_FLAG <= 1'b0;
      UNIFORM_QUANT_FLAG <= 1'b0;
      COND_OVERLAP <= 2'h0;
    end else begin
      PIC_HEIGHT_MB <= fld_height;
      PIC_WIDTH_MB <= fld_width;
      CONCEAL_ENABLE <= fld_conceal;
      ALT_PIC_QUANT <= fld_alt_quant;
      DEBLOCK_INFO_EN <= fld_loop_filter;
      OVERLAP_EN <= fld_overlap;
      IMPLICIT_QUANT_FLAG <= fld_implicit;
      PIC_QUANT <= fld_quant;
      // edge mask has no meaning outside edge-only mode, so it is forced quiet
      ALT_QUANT_EDGE_MASK <= (fld_config == 2'h1) ? fld_edge_mask : 4'h0;
      ALT_QUANT_CONFIG <= fld_config;
      HALF_STEP_QUANT_FLAG <= fld_half_step;
      UNIFORM_QUANT_FLAG <= fld_uniform;
      COND_OVERLAP <= fld_overlap ? fld_cond : 2'h0; // reserved 01 passed on
    end
  end

  // range verdict of the returned word, shared by the data path and the tallies
  wire fetch_zero = out_of_range(IND_DATA_ADDR[31:12], bound_r);
  wire range_on = (bound_r != 20'h00000);

  // indirect address offset and returned-data range filter
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      IND_ADDR_OUT <= 32'h00000000;
      IND_OUT_VALID <= 1'b0;
      IND_DATA_OUT <= 32'h00000000;
    end else begin
      IND_ADDR_OUT <= {base_r, 12'h000} + IND_START;
      // valid is a plain one-cycle echo of the fetch strobe
      IND_OUT_VALID <= IND_DATA_VALID;
      // the fetch was already issued; only the data is replaced
      if (IND_DATA_VALID)
        IND_DATA_OUT <= fetch_zero ? 32'h00000000 : IND_DATA_IN;
    end
  end

  // filter tallies for software; they saturate rather than wrap, so a long run still reads sane
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      zero_cnt_r <= 16'h0000;
      pass_cnt_r <= 16'h0000;
    end else if (IND_DATA_VALID) begin
      if (fetch_zero) begin
        if (zero_cnt_r != 16'hffff)
          zero_cnt_r <= zero_cnt_r + 16'h0001;
      end else begin
        if (pass_cnt_r != 16'hffff)
          pass_cnt_r <= pass_cnt_r + 16'h0001;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    HRDATA = 32'h00000000;
    // outside a read data phase the bus sees zeros
    if (rd_pend_r) begin
      case (rd_addr_r)
        // status packs the parser state with its three command tallies
        `VCF_REG_STAT: HRDATA = {6'h00, state_r, err_cnt_r, ind_cnt_r, pic_cnt_r};
        `VCF_REG_ADDR: HRDATA = IND_ADDR_OUT;
        `VCF_REG_DATA: HRDATA = IND_DATA_OUT;
        `VCF_REG_EFF: HRDATA = {bound_r, 11'h000, range_on};
        `VCF_REG_FILT: HRDATA = {zero_cnt_r, pass_cnt_r};
        `VCF_REG_BASE: HRDATA = {base_r, 12'h000};
        `VCF_REG_BOUND: HRDATA = {bound_r, 12'h000};
        `VCF_REG_PIC1: HRDATA = pic1_r;
        `VCF_REG_PIC2: HRDATA = pic2_r;
        default: HRDATA = 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### vcf_map.vh
// vcf_map.vh: header fields, command codes, register offsets and picture size limits
// assumes inclusion by bare name from the decoder command front end
`ifndef VCF_MAP_VH
`define VCF_MAP_VH
`define VCF_CMD_TYPE 3'h3
`define VCF_PIPE_BSD 2'h2
`define VCF_OPC_VC1 3'h5
`define VCF_SUB_IND 8'h00
`define VCF_SUB_PIC 8'h01
`define VCF_LEN_IND 16'h0001
`define VCF_LEN_PIC 16'h0005
`define VCF_REG_CMD 8'h00
`define VCF_REG_STAT 8'h04
`define VCF_REG_BASE 8'h08
`define VCF_REG_BOUND 8'h0c
`define VCF_REG_PIC1 8'h10
`define VCF_REG_PIC2 8'h14
`define VCF_REG_ADDR 8'h18
`define VCF_REG_DATA 8'h1c
`define VCF_REG_EFF 8'h20
`define VCF_REG_FILT 8'h24
`define VCF_MAX_H 8'h44
`define VCF_MAX_W 8'h78
`endif

// ### vcf_cmd_front_asserts.sv
// vcf_cmd_front_asserts.sv: port checker for the command front end
// assumes one clock domain and a synchronous low reset; bound by name
`timescale 1ns/100ps
`default_nettype none
`include "vcf_map.vh"
module vcf_chk (
  input wire CORE_CLK, // clock
  input wire RST_N, // reset, low
  input wire HSEL, // select
  input wire [31:0] HADDR, // address
  input wire [1:0] HTRANS, // transfer type
  input wire HWRITE, // write
  input wire HREADY, // bus ready
  input wire HREADYOUT, // slave ready
  input wire HRESP, // response
  input wire [31:0] HRDATA, // read data
  input wire [31:0] IND_START, // start address
  input wire IND_DATA_VALID, // fetch valid
  input wire [31:0] IND_DATA_IN, // fetched word
  input wire [31:0] IND_ADDR_OUT, // offset address
  input wire IND_OUT_VALID, // filtered valid
  input wire [31:0] IND_DATA_OUT, // filtered word
  input wire [3:0] ALT_QUANT_EDGE_MASK, // edge mask
  input wire [1:0] ALT_QUANT_CONFIG, // alt quant use
  input wire OVERLAP_EN, // overlap
  input wire [1:0] COND_OVERLAP, // overlap mode
  input wire [7:0] PIC_HEIGHT_MB, // height
  input wire [7:0] PIC_WIDTH_MB, // width
  input wire [4:0] PIC_QUANT, // quantizer
  input wire PIC_STATE_PULSE // commit pulse
);
  reg rd_r, wr_r;
  reg [7:0] adr_r;
  // data phase trackers; a read phase is where hrdata must be valid
  always @(posedge CORE_CLK) begin
    rd_r <= RST_N & HREADY & HSEL & HTRANS[1] & ~HWRITE;
    wr_r <= RST_N & HREADY & HSEL & HTRANS[1] & HWRITE & (HADDR[7:0] == `VCF_REG_CMD);
    adr_r <= HADDR[7:0];
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_okay; HREADYOUT && !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_base; rd_r && adr_r == `VCF_REG_BASE |-> HRDATA[11:0] == 12'h0; endproperty
  a_base: assert property (p_base) else $error("base not page aligned");
  property p_addr; $past(RST_N) |-> IND_ADDR_OUT[11:0] == $past(IND_START[11:0]); endproperty
  a_addr: assert property (p_addr) else $error("offset address wrong");
  property p_zero; IND_DATA_VALID |=> IND_OUT_VALID && (IND_DATA_OUT == $past(IND_DATA_IN) || IND_DATA_OUT == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("fetched word neither passed nor zeroed");
  property p_idle; !IND_DATA_VALID |=> !IND_OUT_VALID && $stable(IND_DATA_OUT); endproperty
  a_idle: assert property (p_idle) else $error("filtered output moved without fetch");
  property p_mask; ALT_QUANT_EDGE_MASK != 4'h0 |-> ALT_QUANT_CONFIG == 2'b01; endproperty
  a_mask: assert property (p_mask) else $error("edge mask outside edge config");
  property p_cond; COND_OVERLAP != 2'b00 |-> OVERLAP_EN; endproperty
  a_cond: assert property (p_cond) else $error("overlap mode without overlap");
  property p_hold;
    !$past(PIC_STATE_PULSE) |-> $stable({PIC_HEIGHT_MB, PIC_WIDTH_MB, PIC_QUANT, ALT_QUANT_CONFIG});
  endproperty
  a_hold: assert property (p_hold) else $error("picture state changed without commit");
  property p_pulse; PIC_STATE_PULSE |=> !PIC_STATE_PULSE; endproperty
  a_pulse: assert property (p_pulse) else $error("commit pulse too long");
  property p_src; PIC_STATE_PULSE |-> $past(wr_r) || $past(wr_r, 2); endproperty
  a_src: assert property (p_src) else $error("commit without command write");
  c_pic: cover property (PIC_STATE_PULSE);
  c_zero: cover property (IND_OUT_VALID && IND_DATA_OUT == 32'h0);
  c_rd: cover property (rd_r && adr_r == `VCF_REG_BASE);
endmodule
bind vcf_cmd_front vcf_chk u_chk (.*);
`default_nettype wire

// ### vcf_mem_model.sv
// vcf_mem_model.sv: memory answering indirect fetches of the front end
// assumes one fetch at a time, answered one clock later
`timescale 1ns/100ps
`default_nettype none
module vcf_mem_model (
  input wire logic clk, // core clock
  input wire logic req, // fetch request
  input wire logic [31:0] addr, // fetch address
  output logic vld, // data valid pulse
  output logic [31:0] data, // returned word
  output logic [31:0] daddr // source address
);
  // memory answers past the bound too; zeroing is the front end's job
  always @(posedge clk) begin
    vld <= req;
    data <= req ? addr ^ 32'h5a5aa5a5 : ~data; // data inverts every cycle between answers
    daddr <= req ? addr : ~daddr;
  end
endmodule
`default_nettype wire

// ### vcf_cmd_front_bench.sv
// vcf_cmd_front_bench.sv: self-checking bench for the command front end
// assumes the memory model answers fetches and the checker is bound
`timescale 1ns/100ps
`default_nettype none
`include "vcf_map.vh"
module vcf_cmd_front_bench;
  logic clk, rst_n, hsel, hwrite, fetch, rd_ph, pls_d;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, ind_start, faddr, base, bnd, d1, d2, q;
  wire [31:0] hrdata, ind_addr, ind_in, ind_da, ind_out;
  wire hro, hresp, ind_v, out_v, pulse;
  wire [39:0] pic;
  logic [39:0] rq[$], pq[$], dq[$];
  int num_errors, comparisons;
  vcf_cmd_front dut (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro), .HREADYOUT(hro), .HRESP(hresp),
    .HRDATA(hrdata), .IND_START(ind_start), .IND_DATA_VALID(ind_v), .IND_DATA_IN(ind_in),
    .IND_DATA_ADDR(ind_da), .IND_ADDR_OUT(ind_addr), .IND_OUT_VALID(out_v), .IND_DATA_OUT(ind_out),
    .PIC_HEIGHT_MB(pic[39:32]), .PIC_WIDTH_MB(pic[31:24]), .CONCEAL_ENABLE(pic[23]),
    .ALT_PIC_QUANT(pic[22:18]), .DEBLOCK_INFO_EN(pic[17]), .OVERLAP_EN(pic[16]),
    .IMPLICIT_QUANT_FLAG(pic[15]), .PIC_QUANT(pic[14:10]), .ALT_QUANT_EDGE_MASK(pic[9:6]),
    .ALT_QUANT_CONFIG(pic[5:4]), .HALF_STEP_QUANT_FLAG(pic[3]), .UNIFORM_QUANT_FLAG(pic[2]),
    .COND_OVERLAP(pic[1:0]), .PIC_STATE_PULSE(pulse));
  vcf_mem_model mem (.clk(clk), .req(fetch), .addr(faddr), .vld(ind_v), .data(ind_in), .daddr(ind_da));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [39:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one single transfer; a read notes its expected word for the watcher
  task automatic ahb(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2; hwrite <= w; haddr <= a; hsel <= 1'b1;
    @(posedge clk); while (hro !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= w ? d : 32'h0;
    if (!w) rq.push_back(d);
    @(posedge clk); while (hro !== 1'b1) @(posedge clk);
  endtask
  task automatic ind_cmd(input logic [31:0] b, u);
    ahb(1, `VCF_REG_CMD, {`VCF_CMD_TYPE, `VCF_PIPE_BSD, `VCF_OPC_VC1, `VCF_SUB_IND, `VCF_LEN_IND});
    ahb(1, `VCF_REG_CMD, b);
    ahb(1, `VCF_REG_CMD, u | 32'h00000abc); // reserved low bits set on purpose
  endtask
  task automatic pic_cmd(input logic [31:0] a, b);
    ahb(1, `VCF_REG_CMD, {`VCF_CMD_TYPE, `VCF_PIPE_BSD, `VCF_OPC_VC1, `VCF_SUB_PIC, `VCF_LEN_PIC});
    ahb(1, `VCF_REG_CMD, a);
    ahb(1, `VCF_REG_CMD, b);
    for (int k = 0; k < 4; k++) ahb(1, `VCF_REG_CMD, $urandom);
    pq.push_back({a[23:16], a[7:0], b[29:16], (b[11:10] == 2'b01) ? b[15:12] : 4'h0, b[11:8],
      b[22] ? b[7:6] : 2'b00});
  endtask
  task automatic fetch_at(input logic [31:0] a, input logic z);
    fetch <= 1'b1; faddr <= a;
    dq.push_back(z ? 32'h0 : a ^ 32'h5a5aa5a5);
    @(posedge clk);
    fetch <= 1'b0;
    @(posedge clk);
  endtask
  // watcher: takes the oldest note whenever a result shows
  always @(posedge clk) begin
    if (rd_ph) check(hrdata, rq.pop_front());
    if (out_v === 1'b1) check(ind_out, dq.pop_front());
    if (pls_d) check(pic, pq.pop_front());
    rd_ph <= hro && hsel && htrans[1] && !hwrite;
    pls_d <= pulse === 1'b1;
  end
  initial begin
    #2000000;
    num_errors++;
    results();
  end
  initial begin
    rst_n = 0; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0; ind_start = 0; fetch = 0; faddr = 0;
    rd_ph = 0; pls_d = 0; num_errors = 0; comparisons = 0;
    void'($urandom(32'hb2a2));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(pic, 40'h0);
    ahb(0, `VCF_REG_BASE, 32'h0);
    ahb(0, 32'h30, 32'h0); // unmapped reads zero
    // one stream only, so no switch inside a picture
    base = ($urandom & 32'h0fffe000) | 32'h1000;
    bnd = base + 32'h2000; // bound above base
    ind_cmd(base, bnd);
    ahb(0, `VCF_REG_BASE, base);
    ahb(0, `VCF_REG_EFF, bnd | 32'h1);
    ind_start <= $urandom;
    repeat (2) @(posedge clk);
    check(ind_addr, base + ind_start);
    for (int i = 0; i < 4; i++) fetch_at(bnd - 32'h1000 + i * 32'h800, i > 1);
    ind_cmd(32'h0, 32'h0);
    fetch_at(bnd, 1'b0);
    repeat (2) @(posedge clk);
    check(ind_addr, ind_start);
    ahb(0, `VCF_REG_FILT, 32'h00020003);
    ahb(0, `VCF_REG_DATA, bnd ^ 32'h5a5aa5a5);
    ahb(0, `VCF_REG_ADDR, ind_start);
    // picture state leads each picture's slices
    for (int i = 0; i < 4; i++) begin
      d1 = (i == 3) ? {8'h0, `VCF_MAX_H, 8'h0, `VCF_MAX_W} : {8'h0, 8'd1 + 8'($urandom % 68), 8'h0, 8'd1 + 8'($urandom % 120)};
      q = 9 + $urandom % 23;
      q = (q < 29) ? q - 3 : 2 * q - 31;
      d2 = ($urandom & 32'hffc0f33f) | (i << 10) | ((i ^ 1) << 6) | (q[4:0] << 16);
      pic_cmd(d1, d2);
      if (i == 1) begin
        ahb(1, `VCF_REG_CMD, 32'h0); // foreign type, dropped alone
        ahb(1, `VCF_REG_CMD, {`VCF_CMD_TYPE, `VCF_PIPE_BSD, `VCF_OPC_VC1, 8'h02, 16'h0});
        ahb(1, `VCF_REG_CMD, 32'hffffffff);
      end
    end
    ahb(0, `VCF_REG_STAT, 32'h00020204);
    repeat (4) @(posedge clk);
    check(rq.size() + dq.size() + pq.size(), 40'h0);
    results();
  end
endmodule
`default_nettype wire
